// ---- core/sru_serial_unit.sv ----
// Serial unit: asynchronous receiver with error flags, simple transmitter, AXI4-Lite slave.
// Assumes rxd is already synchronous to aclk; one clock domain, one clock enable.
// Notes on behaviour
// RQ1: Detect start bit, shift data, check parity/stop
// RQ2: Overrun when full; new data not stored
// RQ3: Error request raised if receive irq enabled
// RQ4: Parity mismatch flags error, data still stored
// RQ5: Stop bit zero flags framing, data stored
// RQ6: Good frame stores data, sets full, requests
// RQ7: Break keeps reception going, framing set again
// RQ8: Transmitter off: pin follows port bits
// RQ9: Clearing transmit enable resets transmitter at once
// RQ10: Synchronous mode: no transmit while errors set
// RQ11: Clearing receive enable keeps error flags
// RQ12: Zero select and divisor gives clock/32 bit rate
// RQ13: Boot hand-over clears transmit and receive enables, keeps irq enable and divisor, pin high
// RQ14: Sample bits mid-period timed from start edge
`timescale 1ns/1ps
module sru_serial_unit
   import sru_pkg::*;
#(
   parameter int DATA_W = 8 // Data bits per frame
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic clk_en, // Freezes all state when low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic rxd, // Receive line
   output logic txd_o, // Transmit pin level
   output logic txd_oe, // Transmit pin drive enable
   output logic rx_data_irq, // Receive-data request level
   output logic rx_error_irq // Receive-error request level
);
   // ==========================================================
   // State
   logic [6:0] ctrl_reg, ctrl_next;
   logic [7:0] brd_reg, brd_next;
   logic [1:0] cks_reg, cks_next;
   logic [1:0] port_reg, port_next; // [1] port_direction, [0] port_out_level
   logic rx_full_flag_reg, rx_full_flag_next, oer_reg, oer_next, per_reg, per_next, fer_reg, fer_next;
   logic tx_empty_flag_reg, tx_empty_flag_next;
   logic [DATA_W-1:0] rdr_reg, rdr_next, tdr_reg, tdr_next;
   sru_state_type rx_st_reg, rx_st_next;
   logic [DATA_W:0] rsr_reg, rsr_next; // rx_shift_reg incl. parity
   logic [3:0] rx_cnt_reg, rx_cnt_next;
   logic [17:0] rx_tick_reg, rx_tick_next;
   logic [DATA_W+1:0] tsr_reg, tsr_next;
   logic [3:0] tx_cnt_reg, tx_cnt_next;
   logic [17:0] tx_tick_reg, tx_tick_next;
   logic tx_busy_reg, tx_busy_next;
   // Two-entry write buffer of the bus slave
   logic [7:0] wb_addr_reg [2], wb_addr_next [2];
   logic [31:0] wb_data_reg [2], wb_data_next [2];
   logic [1:0] wb_cnt_reg, wb_cnt_next;
   logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [7:0] aw_reg, aw_next;
   logic [31:0] w_reg, w_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next, bresp_reg, bresp_next;

   // Bit period in system clocks minus one (RQ12 base rate clock/32)
   function automatic logic [17:0] bit_len(input logic [1:0] cks, input logic [7:0] n);
      logic [17:0] v;
      v = 18'(SRU_BASE_DIV) << (2 * cks);
      bit_len = 18'(v * (18'(n) + 18'h1) - 18'h1); // RQ12
   endfunction : bit_len

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == SRU_CTRL_OFS) || (a == SRU_STAT_OFS) || (a == SRU_RXD_OFS) ||
         (a == SRU_TXD_OFS) || (a == SRU_BRD_OFS) || (a == SRU_PORT_OFS);
   endfunction : is_mapped

   // ==========================================================
   // Bus handshakes; writes drain from the buffer one per cycle
   logic wr_push, wr_pop, rd_take, rd_rdr;
   logic [7:0] wa;
   logic [31:0] wd;
   assign s_axi_awready = !aw_hold_reg && (wb_cnt_reg != 2'd2) && !bvalid_reg;
   assign s_axi_wready = !w_hold_reg && (wb_cnt_reg != 2'd2) && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign wr_pop = wb_cnt_reg != 2'd0;
   assign wa = wb_addr_reg[0];
   assign wd = wb_data_reg[0];
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_rdr = rd_take && (s_axi_araddr == SRU_RXD_OFS);

   // Bus next-state
   always_comb begin
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      aw_hold_next = aw_hold_reg;
      w_hold_next = w_hold_reg;
      aw_next = aw_reg;
      w_next = w_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      wb_addr_next = wb_addr_reg;
      wb_data_next = wb_data_reg;
      wb_cnt_next = wb_cnt_reg;
      wr_push = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_next = 1'b1;
         aw_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_next = 1'b1;
         w_next = s_axi_wdata;
      end
      aw_ok = aw_hold_reg;
      w_ok = w_hold_reg;
      if (wr_pop) begin
         wb_addr_next[0] = wb_addr_reg[1];
         wb_data_next[0] = wb_data_reg[1];
         wb_cnt_next = wb_cnt_reg - 2'd1;
      end
      // Both halves held: queue the write and answer
      if (aw_ok && w_ok) begin
         wr_push = 1'b1;
         wb_addr_next[wb_cnt_next[0]] = aw_reg;
         wb_data_next[wb_cnt_next[0]] = w_reg;
         wb_cnt_next = wb_cnt_next + 2'd1;
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = is_mapped(aw_reg) ? 2'b00 : 2'b10;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (rd_take) begin
         rvalid_next = 1'b1;
         rresp_next = is_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
         case (s_axi_araddr)
            SRU_CTRL_OFS: rdata_next = {25'h0, ctrl_reg};
            SRU_STAT_OFS: rdata_next = {26'h0, tx_busy_reg, rx_full_flag_reg, oer_reg, per_reg,
                                        fer_reg, tx_empty_flag_reg};
            SRU_RXD_OFS: rdata_next = 32'(rdr_reg);
            SRU_TXD_OFS: rdata_next = 32'(tdr_reg);
            SRU_BRD_OFS: rdata_next = {22'h0, cks_reg, brd_reg};
            SRU_PORT_OFS: rdata_next = {30'h0, port_reg};
            default: rdata_next = 32'h0;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // ==========================================================
   // Receiver and flags
   logic bitdone, frame_done, par_bad, stop_bad;
   assign bitdone = rx_tick_reg == 18'h0;

   always_comb begin
      logic wr_ctrl, wr_stat;
      wr_ctrl = wr_pop && (wa == SRU_CTRL_OFS);
      wr_stat = wr_pop && (wa == SRU_STAT_OFS);
      rx_st_next = rx_st_reg;
      rsr_next = rsr_reg;
      rx_cnt_next = rx_cnt_reg;
      rx_tick_next = bitdone ? 18'h0 : rx_tick_reg - 18'h1;
      rdr_next = rdr_reg;
      frame_done = 1'b0;
      par_bad = (^rsr_reg[DATA_W:0]) != ctrl_reg[SRU_C_ODD];
      stop_bad = 1'b0;
      rx_full_flag_next = rx_full_flag_reg;
      oer_next = oer_reg;
      per_next = per_reg;
      fer_next = fer_reg;
      // Software clears flags by writing 0; hardware sets below win
      if (wr_stat) begin
         if (!wd[SRU_S_RX_FULL_FLAG]) rx_full_flag_next = 1'b0;
         if (!wd[SRU_S_OER]) oer_next = 1'b0;
         if (!wd[SRU_S_PER]) per_next = 1'b0;
         if (!wd[SRU_S_FER]) fer_next = 1'b0;
      end
      if (rd_rdr) rx_full_flag_next = 1'b0;
      case (rx_st_reg)
         SRU_IDLE: if (ctrl_reg[SRU_C_RE] && !rxd) begin // RQ1
            rx_st_next = SRU_START;
            rx_tick_next = bit_len(cks_reg, brd_reg) >> 1; // RQ14
         end
         SRU_START: if (bitdone) begin
            if (rxd) rx_st_next = SRU_IDLE; // Glitch, not a start bit
            else begin
               rx_st_next = SRU_DATA;
               rx_cnt_next = 4'h0;
               rx_tick_next = bit_len(cks_reg, brd_reg); // RQ14
            end
         end
         SRU_DATA: if (bitdone) begin
            rsr_next = {rxd, rsr_reg[DATA_W:1]}; // RQ1
            rx_cnt_next = rx_cnt_reg + 4'h1;
            rx_tick_next = bit_len(cks_reg, brd_reg);
            if (rx_cnt_reg == 4'(ctrl_reg[SRU_C_PEN] ? DATA_W : DATA_W - 1))
               rx_st_next = SRU_STOP;
         end
         SRU_STOP: if (bitdone) begin
            rx_st_next = SRU_IDLE; // RQ7
            frame_done = 1'b1;
         end
         default: rx_st_next = SRU_IDLE;
      endcase
      if (frame_done) begin
         stop_bad = !rxd; // RQ5
         if (rx_full_flag_reg) oer_next = 1'b1; // RQ2
         else begin
            rdr_next = ctrl_reg[SRU_C_PEN] ? rsr_reg[DATA_W-1:0] : rsr_reg[DATA_W:1];
            if (ctrl_reg[SRU_C_PEN] && par_bad) per_next = 1'b1; // RQ4
            if (stop_bad) fer_next = 1'b1; // RQ5 RQ7
            if (!(ctrl_reg[SRU_C_PEN] && par_bad) && !stop_bad) rx_full_flag_next = 1'b1; // RQ6
         end
      end
      // Receive enable leaves error flags untouched
      if (wr_ctrl && !wd[SRU_C_RE]) rx_st_next = SRU_IDLE; // RQ11
   end

   // Requests follow flags while enabled
   always_comb begin
      rx_data_irq = rx_full_flag_reg && ctrl_reg[SRU_C_RIE]; // RQ6
      rx_error_irq = (oer_reg || per_reg || fer_reg) && ctrl_reg[SRU_C_RIE]; // RQ3
   end

   // ==========================================================
   // Control, port and transmitter
   always_comb begin
      logic err_any, tx_go;
      err_any = oer_reg || per_reg || fer_reg;
      ctrl_next = ctrl_reg;
      brd_next = brd_reg;
      cks_next = cks_reg;
      port_next = port_reg;
      tdr_next = tdr_reg;
      tx_empty_flag_next = tx_empty_flag_reg;
      tsr_next = tsr_reg;
      tx_cnt_next = tx_cnt_reg;
      tx_tick_next = (tx_tick_reg == 18'h0) ? 18'h0 : tx_tick_reg - 18'h1;
      tx_busy_next = tx_busy_reg;
      tx_go = !tx_busy_reg && !tx_empty_flag_reg && ctrl_reg[SRU_C_TE] &&
         !(ctrl_reg[SRU_C_SYNC] && err_any); // RQ10
      if (tx_go) begin
         tsr_next = {1'b1, tdr_reg, 1'b0};
         tx_busy_next = 1'b1;
         tx_cnt_next = 4'h0;
         tx_empty_flag_next = 1'b1;
         tx_tick_next = bit_len(cks_reg, brd_reg);
      end else if (tx_busy_reg && tx_tick_reg == 18'h0) begin
         tsr_next = {1'b1, tsr_reg[DATA_W+1:1]};
         tx_cnt_next = tx_cnt_reg + 4'h1;
         tx_tick_next = bit_len(cks_reg, brd_reg);
         if (tx_cnt_reg == 4'(DATA_W + 1)) tx_busy_next = 1'b0;
      end
      if (wr_pop) begin
         case (wa)
            SRU_CTRL_OFS: begin
               ctrl_next = wd[6:0] & 7'h3f;
               if (wd[SRU_C_BOOT]) ctrl_next = ctrl_reg & 7'h3c; // RQ13
               if (wd[SRU_C_BOOT]) port_next = 2'b11; // RQ13
            end
            SRU_TXD_OFS: begin
               tdr_next = wd[DATA_W-1:0];
               tx_empty_flag_next = 1'b0;
            end
            SRU_BRD_OFS: begin
               brd_next = wd[7:0];
               cks_next = wd[9:8];
            end
            SRU_PORT_OFS: port_next = wd[1:0];
            default: ;
         endcase
      end
      // Transmitter reset whenever disabled
      if (!ctrl_next[SRU_C_TE]) begin // RQ9
         tx_busy_next = 1'b0;
         tsr_next = '1;
         tx_cnt_next = 4'h0;
         tx_empty_flag_next = 1'b1;
      end
   end

   // Pin: serial data when enabled, else port bits
   always_comb begin
      if (ctrl_reg[SRU_C_TE]) begin
         txd_oe = 1'b1;
         txd_o = tx_busy_reg ? tsr_reg[0] : 1'b1;
      end else begin
         txd_oe = port_reg[1]; // RQ8
         txd_o = port_reg[0]; // RQ8
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= SRU_CTRL_RST;
         brd_reg <= SRU_BRD_RST;
         cks_reg <= SRU_CKS_RST;
         port_reg <= 2'h0;
         {rx_full_flag_reg, oer_reg, per_reg, fer_reg} <= 4'h0;
         tx_empty_flag_reg <= 1'b1;
         rdr_reg <= '0;
         tdr_reg <= '0;
         rx_st_reg <= SRU_IDLE;
         rsr_reg <= '0;
         rx_cnt_reg <= 4'h0;
         rx_tick_reg <= 18'h0;
         tsr_reg <= '1;
         tx_cnt_reg <= 4'h0;
         tx_tick_reg <= 18'h0;
         tx_busy_reg <= 1'b0;
         wb_addr_reg <= '{default: 8'h0};
         wb_data_reg <= '{default: 32'h0};
         wb_cnt_reg <= 2'h0;
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_reg <= 8'h0;
         w_reg <= 32'h0;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= 2'h0;
         bresp_reg <= 2'h0;
      end else if (clk_en) begin
         ctrl_reg <= ctrl_next;
         brd_reg <= brd_next;
         cks_reg <= cks_next;
         port_reg <= port_next;
         {rx_full_flag_reg, oer_reg, per_reg, fer_reg} <= {rx_full_flag_next, oer_next, per_next, fer_next};
         tx_empty_flag_reg <= tx_empty_flag_next;
         rdr_reg <= rdr_next;
         tdr_reg <= tdr_next;
         rx_st_reg <= rx_st_next;
         rsr_reg <= rsr_next;
         rx_cnt_reg <= rx_cnt_next;
         rx_tick_reg <= rx_tick_next;
         tsr_reg <= tsr_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_tick_reg <= tx_tick_next;
         tx_busy_reg <= tx_busy_next;
         wb_addr_reg <= wb_addr_next;
         wb_data_reg <= wb_data_next;
         wb_cnt_reg <= wb_cnt_next;
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         aw_reg <= aw_next;
         w_reg <= w_next;
         bvalid_reg <= bvalid_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         bresp_reg <= bresp_next;
      end
   end

   // ==========================================================
   // Checks
   a_overrun_keeps_rdr: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
      clk_en && frame_done && rx_full_flag_reg |=> oer_reg && $stable(rdr_reg))
      else $error("overrun changed receive data");
   a_err_irq_level: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
      clk_en && frame_done && ctrl_reg[SRU_C_RIE] && !wr_pop &&
      (rx_full_flag_reg || !rxd || (ctrl_reg[SRU_C_PEN] && par_bad)) |=> rx_error_irq)
      else $error("error request missing");
   a_parity_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
      clk_en && frame_done && !rx_full_flag_reg && ctrl_reg[SRU_C_PEN] && par_bad |=> per_reg)
      else $error("parity flag not set");
   a_framing_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
      clk_en && frame_done && !rx_full_flag_reg && !rxd |=> fer_reg)
      else $error("framing flag not set");
   a_good_frame_full: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
      clk_en && frame_done && !rx_full_flag_reg && rxd && !ctrl_reg[SRU_C_PEN] |=> rx_full_flag_reg)
      else $error("full flag not set");
   a_port_pin_ctrl: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
      !ctrl_reg[SRU_C_TE] |-> txd_oe == port_reg[1] && txd_o == port_reg[0])
      else $error("pin not under port control");
   a_tx_off_reset: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
      !ctrl_reg[SRU_C_TE] |-> !tx_busy_reg)
      else $error("transmitter running while disabled");
   a_sync_err_block: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
      ctrl_reg[SRU_C_SYNC] && (oer_reg || per_reg || fer_reg) && !tx_busy_reg |=> !tx_busy_reg)
      else $error("transmit began with error flag");
endmodule : sru_serial_unit

// ---- core/sru_pkg.sv ----
// Package for the serial receive unit: register map, field positions, resets and timing.
// Assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
package sru_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] SRU_CTRL_OFS = 8'h00; // serial_control_reg
   localparam logic [7:0] SRU_STAT_OFS = 8'h04; // serial_status_reg
   localparam logic [7:0] SRU_RXD_OFS = 8'h08; // rx_data_reg
   localparam logic [7:0] SRU_TXD_OFS = 8'h0c; // transmit data
   localparam logic [7:0] SRU_BRD_OFS = 8'h10; // bit_rate_divisor and clock select
   localparam logic [7:0] SRU_PORT_OFS = 8'h14; // port_direction / port_out_level
   // ==========================================================
   // Control field positions
   localparam int SRU_C_TE = 0; // tx_enable
   localparam int SRU_C_RE = 1; // rx_enable
   localparam int SRU_C_RIE = 2; // rx_irq_enable
   localparam int SRU_C_PEN = 3; // parity enable
   localparam int SRU_C_ODD = 4; // odd parity
   localparam int SRU_C_SYNC = 5; // clocked synchronous mode
   localparam int SRU_C_BOOT = 6; // boot hand-over strobe (write 1)
   // Status field positions
   localparam int SRU_S_TX_EMPTY_FLAG = 0; // tx_empty_flag
   localparam int SRU_S_FER = 1; // framing_err_flag
   localparam int SRU_S_PER = 2; // parity_err_flag
   localparam int SRU_S_OER = 3; // overrun_flag
   localparam int SRU_S_RX_FULL_FLAG = 4; // rx_full_flag
   localparam int SRU_S_TBUSY = 5; // transmitter busy
   // ==========================================================
   // Reset values
   localparam logic [6:0] SRU_CTRL_RST = 7'h00;
   localparam logic [7:0] SRU_BRD_RST = 8'h00;
   localparam logic [1:0] SRU_CKS_RST = 2'h0;
   // ==========================================================
   // Timing: one bit lasts 32*4^cks*(div+1) system clocks
   localparam int SRU_BASE_DIV = 32;
   localparam int SRU_SYS_HZ = 200000000;
   typedef enum logic [1:0] {
      SRU_IDLE = 2'b00,
      SRU_START = 2'b01,
      SRU_DATA = 2'b10,
      SRU_STOP = 2'b11
   } sru_state_type;
endpackage : sru_pkg

// ---- verif/sru_host_tx.sv ----
// Remote asynchronous transmitter that drives the receive line of the serial unit.
// Assumes a fixed bit period in system clocks and a frame of 8 data bits plus parity.
`timescale 1ns/1ps
module sru_host_tx #(
   parameter int BIT_CYC = 32 // System clocks per bit
) (
   input wire logic aclk, // System clock
   input wire logic start, // Send one frame when high at an edge
   input wire logic [7:0] data, // Frame data
   input wire logic odd, // Odd parity wanted
   input wire logic bad_par, // Invert the parity bit
   input wire logic stop_val, // Level of the stop bit
   input wire logic brk, // Hold the line low for a whole frame
   output logic rxd, // Line towards the unit
   output logic busy // Frame in flight
);
   logic [10:0] fr;
   int k;
   // ==========================================================
   // Frame sender
   // Start low, data LSB first, parity, stop; the line idles at mark level between frames
   initial begin
      rxd = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge aclk);
         if (start === 1'b1) begin
            busy = 1'b1;
            fr = brk ? 11'h0 : {stop_val, ^data ^ odd ^ bad_par, data, 1'b0};
            for (k = 0; k < 11; k++) begin
               rxd <= fr[k];
               repeat (BIT_CYC) @(posedge aclk);
            end
            rxd <= 1'b1;
            busy = 1'b0;
         end
      end
   end
endmodule : sru_host_tx

// ---- verif/tb_async_serial_rx_error_handling.sv ----
// Self-checking bench for the serial unit: register bus tasks, random and faulty frames.
// Assumes the package, the design and the host transmitter model are compiled first.
`timescale 1ns/1ps
module tb_async_serial_rx_error_handling;
   import sru_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, tx_byte = '0, d1;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_val;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic rxd, txd_o, txd_oe, rx_data_irq, rx_error_irq, h_busy;
   logic tx_go = 1'b0, bad_par = 1'b0, stop_val = 1'b1, brk = 1'b0, odd = 1'b0;
   int n_mismatch = 0, check_count = 0, seed = 23, i;
   // 200 MHz clock
   initial forever #2.5 aclk = ~aclk;
   sru_serial_unit #(.DATA_W(8)) DUT (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .rxd, .txd_o, .txd_oe, .rx_data_irq, .rx_error_irq);
   sru_host_tx #(.BIT_CYC(32)) host (.aclk, .start(tx_go), .data(tx_byte), .odd,
      .bad_par, .stop_val, .brk, .rxd, .busy(h_busy));
   // ==========================================================
   // Reporting
   task automatic end_of_test;
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   task automatic hang;
      n_mismatch++;
      end_of_test();
   endtask : hang
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Status flags expected, given as {full, overrun, parity, framing}
   function automatic logic [31:0] exp_st(input logic [3:0] f);
      return (32'(f[0]) << SRU_S_FER) | (32'(f[1]) << SRU_S_PER) |
         (32'(f[2]) << SRU_S_OER) | (32'(f[3]) << SRU_S_RX_FULL_FLAG);
   endfunction : exp_st
   // ==========================================================
   // Bus and line tasks
   // Ready channels are held high for good, so a response is taken at the edge it shows
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (t = 0; t < 200; t++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      resp = s_axi_bresp;
      if (t == 200) hang();
      // The write lands one edge after its response
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (t = 0; t < 200; t++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      rd_val = s_axi_rdata;
      resp = s_axi_rresp;
      if (t == 200) hang();
   endtask : rd
   task automatic st(input logic [31:0] e);
      rd(SRU_STAT_OFS);
      chk(rd_val & exp_st(4'hf), e);
   endtask : st
   task automatic send(input logic [7:0] d, input logic bp, input logic sv, input logic bk);
      int t;
      tx_byte <= d;
      bad_par <= bp;
      stop_val <= sv;
      brk <= bk;
      tx_go <= 1'b1;
      @(posedge aclk);
      tx_go <= 1'b0;
      @(posedge aclk);
      for (t = 0; t < 1000 && h_busy === 1'b1; t++) @(posedge aclk);
      if (t == 1000) hang();
   endtask : send
   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(SRU_CTRL_OFS);
      chk(rd_val, 32'(SRU_CTRL_RST));
      chk({31'h0, txd_oe}, 32'h0);
      st(32'h0);
      wr(SRU_BRD_OFS, 32'h0);
      // Good frames, first one a lone high bit in the LSB to expose bit order
      for (i = 0; i < 4; i++) begin
         d1 = (i == 0) ? 8'h01 : 8'($random(seed));
         odd <= i[0];
         wr(SRU_CTRL_OFS, {27'h0, i[0], 4'he});
         send(d1, 1'b0, 1'b1, 1'b0);
         st(exp_st(4'b1000));
         chk({30'h0, rx_error_irq, rx_data_irq}, 32'h1);
         rd(SRU_RXD_OFS);
         chk(rd_val, {24'h0, d1});
      end
      // Second frame while full is dropped
      send(8'h5a, 1'b0, 1'b1, 1'b0);
      send(8'ha5, 1'b0, 1'b1, 1'b0);
      st(exp_st(4'b1100));
      chk({31'h0, rx_error_irq}, 32'h1);
      rd(SRU_RXD_OFS);
      chk(rd_val, 32'h5a);
      wr(SRU_STAT_OFS, 32'h0);
      send(8'h3c, 1'b1, 1'b1, 1'b0);
      st(exp_st(4'b0010));
      chk({30'h0, rx_error_irq, rx_data_irq}, 32'h2);
      rd(SRU_RXD_OFS);
      chk(rd_val, 32'h3c);
      // Synchronous mode holds the transmitter while an error flag stands
      wr(SRU_CTRL_OFS, 32'h3f);
      wr(SRU_TXD_OFS, 32'h55);
      rd(SRU_STAT_OFS);
      chk(rd_val & 32'h20, 32'h0);
      wr(SRU_STAT_OFS, 32'h0);
      rd(SRU_STAT_OFS);
      chk(rd_val & 32'h20, 32'h20);
      wr(SRU_PORT_OFS, 32'h2);
      wr(SRU_CTRL_OFS, 32'h1e);
      rd(SRU_STAT_OFS);
      chk(rd_val & 32'h20, 32'h0);
      chk({30'h0, txd_oe, txd_o}, 32'h2);
      wr(SRU_PORT_OFS, 32'h3);
      #1 chk({30'h0, txd_oe, txd_o}, 32'h3);
      // Low stop bit; receiver then switched off at once to block a false start
      send(8'hc3, 1'b0, 1'b0, 1'b0);
      wr(SRU_CTRL_OFS, 32'h1c);
      st(exp_st(4'b0001));
      chk({31'h0, rx_error_irq}, 32'h1);
      rd(SRU_RXD_OFS);
      chk(rd_val, 32'hc3);
      // Break twice: framing comes back after software cleared it
      for (i = 0; i < 2; i++) begin
         wr(SRU_STAT_OFS, 32'h0);
         wr(SRU_CTRL_OFS, 32'h1e);
         send(8'h00, 1'b0, 1'b0, 1'b1);
         wr(SRU_CTRL_OFS, 32'h1c);
         rd(SRU_STAT_OFS);
         chk(rd_val & 32'h2, 32'h2);
      end
      wr(SRU_PORT_OFS, 32'h2);
      wr(SRU_BRD_OFS, 32'h305);
      wr(SRU_CTRL_OFS, 32'h47);
      rd(SRU_CTRL_OFS);
      chk(rd_val, 32'h1c);
      rd(SRU_BRD_OFS);
      chk(rd_val, 32'h305);
      chk({30'h0, txd_oe, txd_o}, 32'h3);
      // Unmapped place answers with a slave error
      rd(8'h40);
      chk(32'(resp), 32'h2);
      wr(8'h40, 32'h1);
      chk(32'(resp), 32'h2);
      end_of_test();
   end
endmodule : tb_async_serial_rx_error_handling
